// file: include/gpx_pkg.sv
// Package for the general-purpose I/O port configuration and interrupt block
package gpx_pkg;

    // Port size
    localparam int unsigned GPX_PINS = 8;

    // Register byte offsets
    localparam logic [7:0] GPX_OFF_DETECT_SET  = 8'h00;
    localparam logic [7:0] GPX_OFF_PIN_INDEX   = 8'h04;
    localparam logic [7:0] GPX_OFF_PIN_VIEW    = 8'h08;
    localparam logic [7:0] GPX_OFF_PAD_SET     = 8'h0c;
    localparam logic [7:0] GPX_OFF_IRQ_ENABLE  = 8'h10;
    localparam logic [7:0] GPX_OFF_IRQ_DISABLE = 8'h14;
    localparam logic [7:0] GPX_OFF_IRQ_CLEAR   = 8'h18;
    localparam logic [7:0] GPX_OFF_RAW_STATUS  = 8'h1c;
    localparam logic [7:0] GPX_OFF_MSK_STATUS  = 8'h20;
    localparam logic [7:0] GPX_OFF_DMA_ENABLE  = 8'h24;
    localparam logic [7:0] GPX_OFF_DMA_DISABLE = 8'h28;
    localparam logic [7:0] GPX_OFF_ALT_FUNC    = 8'h2c;

    // Field positions inside write data
    localparam int unsigned GPX_POS_SETTING = 8;
    localparam int unsigned GPX_POS_TYPE    = 12;
    localparam int unsigned GPX_POS_ALT     = 8;

    // Field positions inside the pin view word
    localparam int unsigned GPX_VIEW_DRIVE = 4;
    localparam int unsigned GPX_VIEW_TYPE  = 8;
    localparam int unsigned GPX_VIEW_ALT   = 12;

    // Detection setting encodings
    localparam logic [2:0] GPX_DET_FALLING = 3'h0;
    localparam logic [2:0] GPX_DET_RISING  = 3'h1;
    localparam logic [2:0] GPX_DET_BOTH    = 3'h2;
    localparam logic [2:0] GPX_DET_LOW     = 3'h3;
    localparam logic [2:0] GPX_DET_HIGH    = 3'h4;

    // Drive encodings
    localparam logic [1:0] GPX_DRIVE_WEAK        = 2'h0;
    localparam logic [1:0] GPX_DRIVE_MEDIUM      = 2'h1;
    localparam logic [1:0] GPX_DRIVE_STRONG      = 2'h2;
    localparam logic [1:0] GPX_DRIVE_STRONG_SLEW = 2'h3;

    // Pad type encodings
    localparam logic [2:0] GPX_PAD_PUSH_PULL     = 3'h0;
    localparam logic [2:0] GPX_PAD_PP_PULLUP     = 3'h1;
    localparam logic [2:0] GPX_PAD_PP_PULLDOWN   = 3'h2;
    localparam logic [2:0] GPX_PAD_OPEN_DRAIN    = 3'h3;
    localparam logic [2:0] GPX_PAD_OD_PULLUP     = 3'h4;
    localparam logic [2:0] GPX_PAD_OD_PULLDOWN   = 3'h5;
    localparam logic [2:0] GPX_PAD_ANALOG        = 3'h6;

    // Values after reset
    localparam logic [2:0] GPX_RST_DETECT = GPX_DET_FALLING;
    localparam logic [1:0] GPX_RST_DRIVE  = GPX_DRIVE_WEAK;
    localparam logic [2:0] GPX_RST_TYPE   = GPX_PAD_PUSH_PULL;
    localparam logic [3:0] GPX_RST_ALT    = 4'h0;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gpx_wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gpx_wb_rsp_t;

endpackage : gpx_pkg

// file: rtl/gpx_port.sv
// Eight-pin port: detection, masking, DMA triggers, pad settings, pin mux
`timescale 1ns/10ps

// Notes on behaviour
// - Each pin can be picked as a DMA trigger source, and unpicked again.
// - A DMA trigger pin still raises its interrupt when that pin is unmasked.
// - Per pin detection: falling, rising, both edges, low level, high level.
// - Software reads back each pin's detection setting as one of five codes.
// - Eight-bit pin mask selects pins, bit n is pin n; others untouched.
// - Drive setting per pin: 2, 4, 8 mA, or 8 mA slew limited.
// - Seven pad types per pin including open drain variants and analog.
// - Pad settings stored for input pins; only pull termination acts on them.
// - Drive and pad type of one pin read back with the written codes.
// - One alternate function code per pin, so one function at a time.
// - Clear drops latched interrupts of selected pins; others stay pending.
// - Interrupt output holds until the pending source is really cleared.
// - Disable masks the selected pins out of the interrupt output.
// - Enable unmasks the selected pins onto the interrupt output.
// - Raw and masked interrupt status readable, one bit per pin.
module gpx_port
    import gpx_pkg::*;
#(
    parameter int unsigned ALT_W = 4
) (
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire gpx_wb_req_t                  wb_req,
    output gpx_wb_rsp_t                       wb_rsp,
    input  wire logic [GPX_PINS-1:0]          pin_in,
    output logic                              irq,
    output logic [GPX_PINS-1:0]               dma_req,
    output logic [GPX_PINS-1:0][1:0]          pad_drive,
    output logic [GPX_PINS-1:0][2:0]          pad_type,
    output logic [GPX_PINS-1:0]               pad_pullup,
    output logic [GPX_PINS-1:0]               pad_pulldown,
    output logic [GPX_PINS-1:0][ALT_W-1:0]    alt_function
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [GPX_PINS-1:0]             sync_a;
        logic [GPX_PINS-1:0]             sync_b;
        logic [GPX_PINS-1:0]             prev;
        logic [GPX_PINS-1:0][2:0]        detect;
        logic [GPX_PINS-1:0][1:0]        drive;
        logic [GPX_PINS-1:0][2:0]        ptype;
        logic [GPX_PINS-1:0][ALT_W-1:0]  alt;
        logic [GPX_PINS-1:0]             irq_mask;
        logic [GPX_PINS-1:0]             dma_en;
        logic [GPX_PINS-1:0]             edge_lat;
        logic [GPX_PINS-1:0]             raw;
        logic [GPX_PINS-1:0]             dma;
        logic [GPX_PINS-1:0]             pull_up;
        logic [GPX_PINS-1:0]             pull_dn;
        logic [2:0]                      pin_idx;
        logic                            ack;
        logic [31:0]                     rdata;
        logic                            irq;
    } gpx_state_t;

    gpx_state_t st;
    gpx_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pad types carrying a weak pull-up
    function automatic logic gpx_has_pullup(input logic [2:0] t);
        return (t == GPX_PAD_PP_PULLUP) || (t == GPX_PAD_OD_PULLUP);
    endfunction : gpx_has_pullup

    // Pad types carrying a weak pull-down
    function automatic logic gpx_has_pulldown(input logic [2:0] t);
        return (t == GPX_PAD_PP_PULLDOWN) || (t == GPX_PAD_OD_PULLDOWN);
    endfunction : gpx_has_pulldown

    // Write strobe for one register, taken on the acknowledged edge
    function automatic logic gpx_wr(input gpx_wb_req_t r, input logic a,
                                    input logic [7:0] off);
        return r.cyc && r.stb && r.we && a && (r.sel[1:0] == 2'h3) && (r.adr == off);
    endfunction : gpx_wr

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic [GPX_PINS-1:0] wmask;
    logic [GPX_PINS-1:0] ev_edge;
    logic [GPX_PINS-1:0] ev_level;
    logic [GPX_PINS-1:0] clr;
    logic [2:0]          w_det;
    logic [1:0]          w_drv;
    logic [2:0]          w_typ;

    always_comb begin
        next_st = st;
        wmask   = wb_req.dat[GPX_PINS-1:0];
        w_det   = wb_req.dat[GPX_POS_SETTING +: 3];
        w_drv   = wb_req.dat[GPX_POS_SETTING +: 2];
        w_typ   = wb_req.dat[GPX_POS_TYPE +: 3];
        clr     = gpx_wr(wb_req, st.ack, GPX_OFF_IRQ_CLEAR) ? wmask : '0;
        ev_edge  = '0;
        ev_level = '0;

        // Two-flop synchroniser, then the previous sample for edges
        next_st.sync_a = pin_in;
        next_st.sync_b = st.sync_a;
        next_st.prev   = st.sync_b;

        // Per pin detection and latching
        for (int i = 0; i < GPX_PINS; i++) begin
            unique case (st.detect[i])
                GPX_DET_FALLING: ev_edge[i]  = st.prev[i] & ~st.sync_b[i];
                GPX_DET_RISING:  ev_edge[i]  = ~st.prev[i] & st.sync_b[i];
                GPX_DET_BOTH:    ev_edge[i]  = st.prev[i] ^ st.sync_b[i];
                GPX_DET_LOW:     ev_level[i] = ~st.sync_b[i];
                GPX_DET_HIGH:    ev_level[i] = st.sync_b[i];
                default:         ev_edge[i]  = 1'b0;
            endcase
        end
        next_st.edge_lat = (st.edge_lat & ~clr) | ev_edge;
        next_st.raw      = next_st.edge_lat | ev_level;
        next_st.dma      = (ev_edge | ev_level) & st.dma_en;

        // Detection setting for selected pins; illegal codes ignored
        if (gpx_wr(wb_req, st.ack, GPX_OFF_DETECT_SET) && (w_det <= GPX_DET_HIGH)) begin
            for (int i = 0; i < GPX_PINS; i++) begin
                if (wmask[i]) begin
                    next_st.detect[i] = w_det;
                end
            end
        end

        // Pad drive and type for selected pins; illegal type ignored
        if (gpx_wr(wb_req, st.ack, GPX_OFF_PAD_SET) && (w_typ <= GPX_PAD_ANALOG)) begin
            for (int i = 0; i < GPX_PINS; i++) begin
                if (wmask[i]) begin
                    next_st.drive[i] = w_drv;
                    next_st.ptype[i] = w_typ;
                end
            end
        end

        // Alternate function: one code per pin
        if (gpx_wr(wb_req, st.ack, GPX_OFF_ALT_FUNC)) begin
            next_st.alt[wb_req.dat[2:0]] = wb_req.dat[GPX_POS_ALT +: ALT_W];
        end

        // Pull termination follows the stored pad type
        for (int i = 0; i < GPX_PINS; i++) begin
            next_st.pull_up[i] = gpx_has_pullup(next_st.ptype[i]);
            next_st.pull_dn[i] = gpx_has_pulldown(next_st.ptype[i]);
        end

        // Mask and trigger set and clear by pin mask
        if (gpx_wr(wb_req, st.ack, GPX_OFF_IRQ_ENABLE)) begin
            next_st.irq_mask = st.irq_mask | wmask;
        end
        if (gpx_wr(wb_req, st.ack, GPX_OFF_IRQ_DISABLE)) begin
            next_st.irq_mask = st.irq_mask & ~wmask;
        end
        if (gpx_wr(wb_req, st.ack, GPX_OFF_DMA_ENABLE)) begin
            next_st.dma_en = st.dma_en | wmask;
        end
        if (gpx_wr(wb_req, st.ack, GPX_OFF_DMA_DISABLE)) begin
            next_st.dma_en = st.dma_en & ~wmask;
        end
        if (gpx_wr(wb_req, st.ack, GPX_OFF_PIN_INDEX)) begin
            next_st.pin_idx = wb_req.dat[2:0];
        end

        // Interrupt output stays up while any unmasked source is pending
        next_st.irq = |(next_st.raw & next_st.irq_mask);

        // Bus answer: one wait state, ack for a single cycle
        next_st.ack   = wb_req.cyc && wb_req.stb && !st.ack;
        next_st.rdata = '0;
        if (wb_req.cyc && wb_req.stb && !wb_req.we && !st.ack) begin
            unique case (wb_req.adr)
                GPX_OFF_PIN_INDEX:   next_st.rdata[2:0] = st.pin_idx;
                GPX_OFF_PIN_VIEW: begin
                    next_st.rdata[2:0] = st.detect[st.pin_idx];
                    next_st.rdata[GPX_VIEW_DRIVE +: 2] = st.drive[st.pin_idx];
                    next_st.rdata[GPX_VIEW_TYPE +: 3]  = st.ptype[st.pin_idx];
                    next_st.rdata[GPX_VIEW_ALT +: ALT_W] = st.alt[st.pin_idx];
                end
                GPX_OFF_IRQ_ENABLE:  next_st.rdata[GPX_PINS-1:0] = st.irq_mask;
                GPX_OFF_RAW_STATUS:  next_st.rdata[GPX_PINS-1:0] = st.raw;
                GPX_OFF_MSK_STATUS:  next_st.rdata[GPX_PINS-1:0] = st.raw & st.irq_mask;
                GPX_OFF_DMA_ENABLE:  next_st.rdata[GPX_PINS-1:0] = st.dma_en;
                default:             next_st.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Single state register with synchronous reset
    always_ff @(posedge clk) begin
        if (srst) begin
            st        <= '0;
            st.detect <= {GPX_PINS{GPX_RST_DETECT}};
            st.drive  <= {GPX_PINS{GPX_RST_DRIVE}};
            st.ptype  <= {GPX_PINS{GPX_RST_TYPE}};
            st.alt    <= {GPX_PINS{GPX_RST_ALT}};
        end else begin
            st <= next_st;
        end
    end

    // Outputs from state
    assign wb_rsp.ack   = st.ack;
    assign wb_rsp.dat   = st.rdata;
    assign irq          = st.irq;
    assign dma_req      = st.dma;
    assign pad_drive    = st.drive;
    assign pad_type     = st.ptype;
    assign pad_pullup   = st.pull_up;
    assign pad_pulldown = st.pull_dn;
    assign alt_function = st.alt;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_wr(logic [7:0] off);
        gpx_wr(wb_req, st.ack, off);
    endsequence

    // Rising edge seen on the synchronised sample of one pin
    sequence s_rise_in(int unsigned p);
        st.sync_b[p] && !st.prev[p] && (st.detect[p] == GPX_DET_RISING);
    endsequence

    // Bus answer: one wait state, then a single ack cycle
    chk_ack_single: assert property (st.ack |=> !st.ack)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property (wb_req.cyc && wb_req.stb && !st.ack |=> st.ack)
        else $error("request not answered in one cycle");

    // Clear acts on the selected latches only
    chk_clear_pins: assert property (s_wr(GPX_OFF_IRQ_CLEAR) |=>
        ((st.edge_lat & $past(wmask) & ~$past(ev_edge)) == '0))
        else $error("selected latch survived a clear");
    chk_clear_others: assert property (s_wr(GPX_OFF_IRQ_CLEAR) |=>
        ((st.edge_lat & $past(st.edge_lat) & ~$past(wmask)) == ($past(st.edge_lat) & ~$past(wmask))))
        else $error("unselected latch lost on clear");

    // Mask updates by pin mask; a fully masked port stays quiet
    chk_enable_sets: assert property (s_wr(GPX_OFF_IRQ_ENABLE) |=>
        ((st.irq_mask & $past(wmask)) == $past(wmask)))
        else $error("enable did not unmask");
    chk_disable_drops: assert property (s_wr(GPX_OFF_IRQ_DISABLE) |=>
        ((st.irq_mask & $past(wmask)) == '0))
        else $error("disable did not mask");
    chk_mask_blocks: assert property ((st.irq_mask == '0)
        && !gpx_wr(wb_req, st.ack, GPX_OFF_IRQ_ENABLE) |=> !st.irq)
        else $error("fully masked port raised its interrupt");

    // Trigger pins keep their interrupt; triggers need a selection
    chk_dma_keeps_irq: assert property ((|(st.edge_lat & st.irq_mask & st.dma_en))
        && clr == '0 && !gpx_wr(wb_req, st.ack, GPX_OFF_IRQ_DISABLE) |=> st.irq)
        else $error("trigger pin lost its interrupt");
    chk_dma_gated: assert property (!st.dma_en[0] |=> !st.dma[0])
        else $error("unselected pin raised a trigger");

    // Pending output holds until a clear or a mask lands
    chk_irq_holds: assert property (st.irq && clr == '0 && !gpx_wr(wb_req, st.ack,
        GPX_OFF_IRQ_DISABLE) && ((st.raw & st.irq_mask) == (st.edge_lat & st.irq_mask))
        |=> st.irq)
        else $error("interrupt dropped without a clear");

    // Edge latching and level following
    chk_rise_latch: assert property (!st.sync_b[0] ##1 s_rise_in(0) |=>
        st.edge_lat[0])
        else $error("rising edge not latched");
    chk_level_follows: assert property ((st.detect[3] == GPX_DET_HIGH) && st.sync_b[3]
        |=> st.raw[3])
        else $error("high level not reported");

    // Setting writes land on selected pins and leave the others alone
    chk_detect_write: assert property (gpx_wr(wb_req, st.ack, GPX_OFF_DETECT_SET)
        && w_det <= GPX_DET_HIGH && wmask[0] |=> st.detect[0] == $past(w_det))
        else $error("detection setting not stored");
    chk_detect_keep: assert property (gpx_wr(wb_req, st.ack, GPX_OFF_DETECT_SET)
        && !wmask[1] |=> st.detect[1] == $past(st.detect[1]))
        else $error("unselected pin setting changed");
    chk_pad_write: assert property (gpx_wr(wb_req, st.ack, GPX_OFF_PAD_SET)
        && w_typ <= GPX_PAD_ANALOG && wmask[0]
        |=> st.drive[0] == $past(w_drv) && st.ptype[0] == $past(w_typ))
        else $error("pad setting not stored");

    // Pull-up flag stands together with the stored pad type
    chk_pull_follows: assert property (st.pull_up[0] == ((st.ptype[0] == GPX_PAD_PP_PULLUP)
        || (st.ptype[0] == GPX_PAD_OD_PULLUP)))
        else $error("pull-up flag disagrees with pad type");

endmodule : gpx_port

// file: test/gpx_pin_model.sv
// Model of the outside pins driving the port inputs
`timescale 1ns/10ps
module gpx_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] lvl,
    output logic      [7:0] pin_in
);
    // Start from a known low level
    initial pin_in = 8'h00;
    // Commanded level lands just after an edge and then stands still
    always @(posedge clk) begin
        pin_in <= lvl;
    end
endmodule : gpx_pin_model

// file: test/gpx_port_tb.sv
// Self-checking bench for the port configuration and interrupt block
`timescale 1ns/10ps
module gpx_port_tb;
    import gpx_pkg::*;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    gpx_wb_req_t         wb_req = '0;
    gpx_wb_rsp_t         wb_rsp;
    logic [7:0]          pin_lvl = 8'h00;
    logic [7:0]          pin_in;
    logic [7:0]          dma_req;
    logic [7:0]          pad_pullup;
    logic [7:0]          pad_pulldown;
    logic                irq;
    logic [7:0][1:0]     pad_drive;
    logic [7:0][2:0]     pad_type;
    logic [7:0][3:0]     alt_function;
    logic [31:0]         rd;
    int                  err_count = 0;
    int                  comparisons = 0;
    int                  cycles = 0;
    int                  m_det[8], m_drv[8], m_typ[8], m_alt[8];
    int                  msk, cd;
    ////////////////////////////////////////////////////////////////////////////
    gpx_pin_model gpx_pin_model_i (.clk(clk), .lvl(pin_lvl), .pin_in(pin_in));
    gpx_port #(.ALT_W(4)) gpx_port_i (.clk(clk), .srst(srst), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .pin_in(pin_in), .irq(irq), .dma_req(dma_req),
        .pad_drive(pad_drive), .pad_type(pad_type), .pad_pullup(pad_pullup),
        .pad_pulldown(pad_pulldown), .alt_function(alt_function));
    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
    endtask : wb
    // Read back every pin through the index and compare with the model
    task automatic view_all();
        for (int p = 0; p < 8; p++) begin
            wb(1'b1, GPX_OFF_PIN_INDEX, p);
            wb(1'b0, GPX_OFF_PIN_VIEW, 0);
            check(rd, m_det[p] | m_drv[p] << 4 | m_typ[p] << 8 | m_alt[p] << 12);
            check(pad_drive[p], m_drv[p]);
            check(pad_type[p], m_typ[p]);
            check(pad_pullup[p], m_typ[p] == 1 || m_typ[p] == 4);
            check(pad_pulldown[p], m_typ[p] == 2 || m_typ[p] == 5);
            check(alt_function[p], m_alt[p]);
        end
    endtask : view_all
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (m_det[i]) {m_det[i], m_drv[i], m_typ[i], m_alt[i]} = '0;
        void'($urandom(38));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // Reset state and an unmapped address
        view_all();
        wb(1'b0, 8'h30, 0);
        check(rd, 0);
        wb(1'b0, GPX_OFF_IRQ_ENABLE, 0);
        check(rd, 0);
        $display("test reset done");
        // Every detect code on a random pin set, then an illegal code
        for (int c = 0; c < 6; c++) begin
            msk = $urandom % 256;
            wb(1'b1, GPX_OFF_DETECT_SET, c << 8 | msk);
            foreach (m_det[p]) if (msk[p] && c < 5) m_det[p] = c;
        end
        view_all();
        $display("test detect done");
        // Pad settings with every drive code, one illegal type, pin mux codes
        for (int c = 0; c < 5; c++) begin
            msk = $urandom % 256;
            cd = (c == 4) ? 7 : $urandom % 7;
            wb(1'b1, GPX_OFF_PAD_SET, cd << 12 | (c % 4) << 8 | msk);
            foreach (m_drv[p]) if (msk[p] && cd < 7) {m_drv[p], m_typ[p]} = {c % 4, cd};
            cd = $urandom % 16;
            wb(1'b1, GPX_OFF_ALT_FUNC, cd << 8 | c + 3);
            m_alt[c + 3] = cd;
        end
        view_all();
        $display("test pad done");
        // Rising edges latch; mask, DMA trigger, clear and disable
        wb(1'b1, GPX_OFF_DETECT_SET, 32'h01ff);
        wb(1'b1, GPX_OFF_IRQ_ENABLE, 32'h05);
        wb(1'b1, GPX_OFF_DMA_ENABLE, 32'h01);
        pin_lvl <= 8'h07;
        // Trigger pulse stands one cycle, four edges after the level is commanded
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(dma_req, 32'h01);
        repeat (4) @(posedge clk);
        check(dma_req, 32'h00);
        wb(1'b0, GPX_OFF_RAW_STATUS, 0);
        check(rd, 32'h07);
        wb(1'b0, GPX_OFF_MSK_STATUS, 0);
        check(rd, 32'h05);
        check(irq, 1'b1);
        wb(1'b0, GPX_OFF_DMA_ENABLE, 0);
        check(rd, 32'h01);
        wb(1'b1, GPX_OFF_IRQ_CLEAR, 32'h01);
        wb(1'b0, GPX_OFF_RAW_STATUS, 0);
        check(rd, 32'h06);
        check(irq, 1'b1);
        wb(1'b1, GPX_OFF_IRQ_DISABLE, 32'h04);
        wb(1'b0, GPX_OFF_MSK_STATUS, 0);
        check(rd, 32'h00);
        check(irq, 1'b0);
        wb(1'b1, GPX_OFF_IRQ_CLEAR, 32'h06);
        wb(1'b1, GPX_OFF_IRQ_ENABLE, 32'hff);
        wb(1'b1, GPX_OFF_DMA_DISABLE, 32'h01);
        wb(1'b0, GPX_OFF_DMA_ENABLE, 0);
        check(rd, 32'h00);
        check(irq, 1'b0);
        $display("test edge done");
        // Level modes follow the pin while it holds the programmed level
        wb(1'b1, GPX_OFF_DETECT_SET, 32'h0408);
        wb(1'b1, GPX_OFF_DETECT_SET, 32'h0310);
        repeat (4) @(posedge clk);
        wb(1'b0, GPX_OFF_RAW_STATUS, 0);
        check(rd, 32'h10);
        pin_lvl <= 8'h1f;
        repeat (6) @(posedge clk);
        wb(1'b0, GPX_OFF_RAW_STATUS, 0);
        check(rd, 32'h08);
        check(irq, 1'b1);
        $display("test level done");
        tally_and_finish();
    end
endmodule : gpx_port_tb
